// File: rtl/debug_serial_unit_regs.sv
// Register back end of the debug serial unit with an AXI4-Lite slave.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Status tx empty flag mirrors tx DMA empty.
// - Status rx full flag mirrors rx DMA full.
// - Status debug write flag mirrors core output.
// - Status debug read flag mirrors core output.
// - Receive holding shows last character, bits 7:0.
// - Transmit holding write queues one character.
// - Divisor 0 stops, 1 direct, else 16x.
// - Id bit 31 flags an extension register.
// - Extension reads zero when no extension.
// - Force bit holds tap reset low.
// - First memory size field uses size codes.
// - Second size field, bits 15:12, same codes.
// - Sram size field in bits 19:16.
// - Memory type field in bits 30:28.
// - Bits 4:0 report silicon version.
// - Bits 27:20 hold family code.
// - Bits 7:5 hold core type code.
// - Rx ready set on character, cleared by read.
// - Tx free low while character waits.
module debug_serial_unit_regs #(
   parameter logic [4:0]  VERSION    = 5'h01, // Arbitrary value.
   parameter logic [2:0]  CORE_TYPE  = 3'h6,  // Arbitrary value.
   parameter logic [7:0]  FAMILY     = 8'hA5, // Arbitrary value.
   parameter logic [3:0]  SRAM_SIZE  = 4'h1,
   parameter logic [3:0]  NVM1_SIZE  = 4'h0,
   parameter logic [3:0]  NVM2_SIZE  = 4'h0,
   parameter logic [2:0]  NVM_TYPE   = 3'h0,
   parameter logic        EXT_PRESENT = 1'h0,
   parameter logic [31:0] EXT_VALUE  = 32'h0000_0000 // Arbitrary value.
) (
   input  wire logic        aclk,                // 250 MHz clock.
   input  wire logic        aresetn,             // Synchronous reset.
   input  wire logic [31:0] s_axi_awaddr,        // Write address.
   input  wire logic        s_axi_awvalid,       // Write address valid.
   output logic             s_axi_awready,       // Write address ready.
   input  wire logic [31:0] s_axi_wdata,         // Write data.
   input  wire logic [3:0]  s_axi_wstrb,         // Write strobes.
   input  wire logic        s_axi_wvalid,        // Write data valid.
   output logic             s_axi_wready,        // Write data ready.
   output logic [1:0]       s_axi_bresp,         // Write response.
   output logic             s_axi_bvalid,        // Write response valid.
   input  wire logic        s_axi_bready,        // Write response ready.
   input  wire logic [31:0] s_axi_araddr,        // Read address.
   input  wire logic        s_axi_arvalid,       // Read address valid.
   output logic             s_axi_arready,       // Read address ready.
   output logic [31:0]      s_axi_rdata,         // Read data.
   output logic [1:0]       s_axi_rresp,         // Read response.
   output logic             s_axi_rvalid,        // Read data valid.
   input  wire logic        s_axi_rready,        // Read data ready.
   input  wire logic        tx_dma_buffer_empty, // Tx DMA buffer empty.
   input  wire logic        rx_dma_buffer_full,  // Rx DMA buffer full.
   input  wire logic        debug_channel_write_pending, // Core write.
   input  wire logic        debug_channel_read_pending,  // Core read.
   input  wire logic        rx_enabled,          // Receiver enabled.
   input  wire logic        rx_char_valid,       // Receiver char pulse.
   input  wire logic [7:0]  rx_char_data,        // Receiver character.
   input  wire logic        tx_enabled,          // Transmitter enabled.
   input  wire logic        tx_char_taken,       // Shifter took char.
   output logic             tx_char_pending,     // Character waiting.
   output logic [7:0]       character_to_send,   // Waiting character.
   output logic             baud_tick,           // Baud enable pulse.
   input  wire logic        power_on_reset_n,    // Power-on reset pin.
   output logic             tap_reset_n          // Tap reset to core.
);
   localparam dbg_serial_pkg::chip_id_t CHIP_ID = '{
      ext_present: EXT_PRESENT,
      nvm_type:    NVM_TYPE,
      family:      FAMILY,
      sram_size:   SRAM_SIZE,
      nvm2_size:   NVM2_SIZE,
      nvm1_size:   NVM1_SIZE,
      core_type:   CORE_TYPE,
      version:     VERSION
   };

   logic        aw_have_q;
   logic [31:0] aw_addr_q;
   logic        w_have_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [15:0] baud_div_q;
   logic        force_tap_q;
   logic [7:0]  rx_data_q;
   logic        rx_ready_q;
   logic        tx_pending_q;
   logic [7:0]  tx_data_q;
   logic [19:0] baud_cnt_q;
   logic        baud_tick_q;
   logic        por_meta_q;
   logic        por_sync_q;
   logic        tap_reset_n_q;

   logic        aw_take;
   logic        w_take;
   logic        do_write;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_mapped;
   logic        ar_take;
   logic        rd_rx_hold;
   logic        wr_tx_hold;
   logic [31:0] status_word;
   logic [31:0] rd_word;
   logic        rd_mapped;
   logic [19:0] baud_period;

   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready  = !w_have_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   assign aw_take  = s_axi_awvalid && s_axi_awready;
   assign w_take   = s_axi_wvalid && s_axi_wready;
   assign do_write = (aw_have_q || aw_take) && (w_have_q || w_take);
   assign wr_addr  = aw_have_q ? aw_addr_q : s_axi_awaddr;
   assign wr_data  = w_have_q ? w_data_q : s_axi_wdata;
   assign wr_strb  = w_have_q ? w_strb_q : s_axi_wstrb;
   assign ar_take  = s_axi_arvalid && s_axi_arready;
   assign rd_rx_hold = ar_take && s_axi_araddr == dbg_serial_pkg::ADDR_RX_HOLD;
   assign wr_tx_hold = do_write && wr_strb[0]
                       && wr_addr == dbg_serial_pkg::ADDR_TX_HOLD;

   always_comb begin
      case (wr_addr)
         dbg_serial_pkg::ADDR_STATUS,
         dbg_serial_pkg::ADDR_RX_HOLD,
         dbg_serial_pkg::ADDR_TX_HOLD,
         dbg_serial_pkg::ADDR_BAUD_DIV,
         dbg_serial_pkg::ADDR_CHIP_ID,
         dbg_serial_pkg::ADDR_CHIP_EXT,
         dbg_serial_pkg::ADDR_FORCE_TAP: wr_mapped = 1'b1;
         default: wr_mapped = 1'b0;
      endcase
   end

   // Write channel: address and data are held until both are present.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
         w_have_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= dbg_serial_pkg::RESP_OKAY;
      end else begin
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_mapped ? dbg_serial_pkg::RESP_OKAY
                                   : dbg_serial_pkg::RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_have_q <= 1'b1;
               aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
               w_have_q <= 1'b1;
               w_data_q <= s_axi_wdata;
               w_strb_q <= s_axi_wstrb;
            end
            if (bvalid_q && s_axi_bready) begin
               bvalid_q <= 1'b0;
            end
         end
      end
   end

   // Writable registers; writes to read-only words change nothing.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_div_q  <= dbg_serial_pkg::BAUD_DIV_RESET;
         force_tap_q <= dbg_serial_pkg::FORCE_TAP_RESET;
      end else if (do_write) begin
         if (wr_addr == dbg_serial_pkg::ADDR_BAUD_DIV) begin
            if (wr_strb[0]) begin
               baud_div_q[7:0] <= wr_data[7:0];
            end
            if (wr_strb[1]) begin
               baud_div_q[15:8] <= wr_data[15:8];
            end
         end
         if (wr_addr == dbg_serial_pkg::ADDR_FORCE_TAP && wr_strb[0]) begin
            force_tap_q <= wr_data[dbg_serial_pkg::FORCE_TAP_BIT];
         end
      end
   end

   // Receive holding and its ready flag; a new character beats the read.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_data_q  <= 8'h00;
         rx_ready_q <= 1'b0;
      end else begin
         if (rx_char_valid) begin
            rx_data_q <= rx_char_data;
         end
         if (!rx_enabled) begin
            rx_ready_q <= 1'b0;
         end else if (rx_char_valid) begin
            rx_ready_q <= 1'b1;
         end else if (rd_rx_hold) begin
            rx_ready_q <= 1'b0;
         end
      end
   end

   // Transmit holding; a new write beats the shifter taking the old one.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_data_q    <= 8'h00;
         tx_pending_q <= 1'b0;
      end else if (wr_tx_hold) begin
         tx_data_q    <= wr_data[7:0];
         tx_pending_q <= 1'b1;
      end else if (tx_char_taken && tx_pending_q) begin
         tx_pending_q <= 1'b0;
      end
   end

   assign tx_char_pending   = tx_pending_q;
   assign character_to_send = tx_data_q;

   // Baud enable: every cycle for 1, every 16 x divisor cycles above.
   assign baud_period = {baud_div_q, 4'h0};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_cnt_q  <= 20'h00000;
         baud_tick_q <= 1'b0;
      end else if (baud_div_q == 16'h0000) begin
         baud_cnt_q  <= 20'h00000;
         baud_tick_q <= 1'b0;
      end else if (baud_div_q == 16'h0001) begin
         baud_cnt_q  <= 20'h00000;
         baud_tick_q <= 1'b1;
      end else if (baud_cnt_q >= baud_period - 20'h00001) begin
         baud_cnt_q  <= 20'h00000;
         baud_tick_q <= 1'b1;
      end else begin
         baud_cnt_q  <= baud_cnt_q + 20'h00001;
         baud_tick_q <= 1'b0;
      end
   end

   assign baud_tick = baud_tick_q;

   // Tap reset follows the synchronised power-on reset unless forced.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         por_meta_q    <= 1'b0;
         por_sync_q    <= 1'b0;
         tap_reset_n_q <= 1'b0;
      end else begin
         por_meta_q    <= power_on_reset_n;
         por_sync_q    <= por_meta_q;
         tap_reset_n_q <= force_tap_q ? 1'b0 : por_sync_q;
      end
   end

   assign tap_reset_n = tap_reset_n_q;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[dbg_serial_pkg::ST_RX_READY]  = rx_ready_q;
      status_word[dbg_serial_pkg::ST_TX_FREE]   =
         !tx_pending_q && tx_enabled;
      status_word[dbg_serial_pkg::ST_TX_BUF_E]  = tx_dma_buffer_empty;
      status_word[dbg_serial_pkg::ST_RX_BUF_F]  = rx_dma_buffer_full;
      status_word[dbg_serial_pkg::ST_DBG_WRITE] =
         debug_channel_write_pending;
      status_word[dbg_serial_pkg::ST_DBG_READ]  =
         debug_channel_read_pending;
   end

   // Read decode; the write-only transmit word reads as zero.
   always_comb begin
      rd_word   = 32'h0000_0000;
      rd_mapped = 1'b1;
      case (s_axi_araddr)
         dbg_serial_pkg::ADDR_STATUS:    rd_word = status_word;
         dbg_serial_pkg::ADDR_RX_HOLD:   rd_word = {24'h000000, rx_data_q};
         dbg_serial_pkg::ADDR_TX_HOLD:   rd_word = 32'h0000_0000;
         dbg_serial_pkg::ADDR_BAUD_DIV:  rd_word = {16'h0000, baud_div_q};
         // Bits 31..0 are packed by the struct layout.
         dbg_serial_pkg::ADDR_CHIP_ID:   rd_word = CHIP_ID;
         dbg_serial_pkg::ADDR_CHIP_EXT:
            rd_word = CHIP_ID.ext_present ? EXT_VALUE : 32'h0000_0000;
         dbg_serial_pkg::ADDR_FORCE_TAP: rd_word = {31'h0000_0000, force_tap_q};
         default:                        rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= dbg_serial_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_mapped ? dbg_serial_pkg::RESP_OKAY
                               : dbg_serial_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   property p_tx_buf_empty;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && s_axi_araddr == dbg_serial_pkg::ADDR_STATUS) |=>
         rdata_q[dbg_serial_pkg::ST_TX_BUF_E] == $past(tx_dma_buffer_empty);
   endproperty
   a_tx_buf_empty: assert property (p_tx_buf_empty)
      else $error("Status tx empty flag does not mirror DMA.");

   property p_rx_buf_full;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && s_axi_araddr == dbg_serial_pkg::ADDR_STATUS) |=>
         rdata_q[dbg_serial_pkg::ST_RX_BUF_F] == $past(rx_dma_buffer_full);
   endproperty
   a_rx_buf_full: assert property (p_rx_buf_full)
      else $error("Status rx full flag does not mirror DMA.");

   property p_dbg_flags;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && s_axi_araddr == dbg_serial_pkg::ADDR_STATUS) |=>
         rdata_q[31:30] == $past({debug_channel_read_pending,
                                  debug_channel_write_pending});
   endproperty
   a_dbg_flags: assert property (p_dbg_flags)
      else $error("Debug channel flags do not mirror the core.");

   property p_rx_char;
      @(posedge aclk) disable iff (!aresetn)
      (rx_char_valid ##1 (rd_rx_hold && !rx_char_valid)) |=>
         rdata_q == {24'h000000, $past(rx_char_data, 2)};
   endproperty
   a_rx_char: assert property (p_rx_char)
      else $error("Receive holding does not show last character.");

   property p_baud_direct;
      @(posedge aclk) disable iff (!aresetn)
      (baud_div_q == 16'h0001)[*2] |-> baud_tick;
   endproperty
   a_baud_direct: assert property (p_baud_direct)
      else $error("Divisor one does not tick every cycle.");

   property p_baud_stop;
      @(posedge aclk) disable iff (!aresetn)
      (baud_div_q == 16'h0000)[*2] |-> !baud_tick;
   endproperty
   a_baud_stop: assert property (p_baud_stop)
      else $error("Divisor zero still ticks.");

   property p_ext_zero;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && s_axi_araddr == dbg_serial_pkg::ADDR_CHIP_EXT
       && !EXT_PRESENT) |=> rdata_q == 32'h0000_0000;
   endproperty
   a_ext_zero: assert property (p_ext_zero)
      else $error("Extension reads nonzero without extension.");

   property p_force_tap;
      @(posedge aclk) disable iff (!aresetn)
      force_tap_q |=> !tap_reset_n;
   endproperty
   a_force_tap: assert property (p_force_tap)
      else $error("Tap reset not held low while forced.");

   property p_rx_clear;
      @(posedge aclk) disable iff (!aresetn)
      (rd_rx_hold && !rx_char_valid) |=> !rx_ready_q;
   endproperty
   a_rx_clear: assert property (p_rx_clear)
      else $error("Rx ready not cleared by holding read.");

   property p_tx_busy;
      @(posedge aclk) disable iff (!aresetn)
      wr_tx_hold |=> !status_word[dbg_serial_pkg::ST_TX_FREE];
   endproperty
   a_tx_busy: assert property (p_tx_busy)
      else $error("Tx free flag set with character waiting.");

   property p_baud_upper;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && s_axi_araddr == dbg_serial_pkg::ADDR_BAUD_DIV) |=>
         rdata_q[31:16] == 16'h0000;
   endproperty
   a_baud_upper: assert property (p_baud_upper)
      else $error("Unused divisor bits read nonzero.");
endmodule

`default_nettype wire

// File: include/dbg_serial_pkg.sv
// Package with the register map, field layout and codes of the debug serial unit.
package dbg_serial_pkg;
   localparam logic [31:0] ADDR_STATUS    = 32'hFFFFF214;
   localparam logic [31:0] ADDR_RX_HOLD   = 32'hFFFFF218;
   localparam logic [31:0] ADDR_TX_HOLD   = 32'hFFFFF21C;
   localparam logic [31:0] ADDR_BAUD_DIV  = 32'hFFFFF220;
   localparam logic [31:0] ADDR_CHIP_ID   = 32'hFFFFF240;
   localparam logic [31:0] ADDR_CHIP_EXT  = 32'hFFFFF244;
   localparam logic [31:0] ADDR_FORCE_TAP = 32'hFFFFF248;

   localparam int ST_RX_READY   = 0;
   localparam int ST_TX_FREE    = 1;
   localparam int ST_TX_BUF_E   = 11;
   localparam int ST_RX_BUF_F   = 12;
   localparam int ST_DBG_WRITE  = 30;
   localparam int ST_DBG_READ   = 31;
   localparam int FORCE_TAP_BIT = 0;

   localparam logic [15:0] BAUD_DIV_RESET  = 16'h0000;
   localparam logic        FORCE_TAP_RESET = 1'h0;
   localparam logic [19:0] BAUD_OVERSAMPLE = 20'h00010;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Memory size codes shared by both nonvolatile size fields.
   localparam logic [3:0] NVM_NONE  = 4'h0;
   localparam logic [3:0] NVM_8K    = 4'h1;
   localparam logic [3:0] NVM_16K   = 4'h2;
   localparam logic [3:0] NVM_32K   = 4'h3;
   localparam logic [3:0] NVM_64K   = 4'h5;
   localparam logic [3:0] NVM_128K  = 4'h7;
   localparam logic [3:0] NVM_256K  = 4'h9;
   localparam logic [3:0] NVM_512K  = 4'hA;
   localparam logic [3:0] NVM_1024K = 4'hC;
   localparam logic [3:0] NVM_2048K = 4'hE;

   localparam logic [2:0] NVM_TYPE_ROM       = 3'h0;
   localparam logic [2:0] NVM_TYPE_ROMLESS   = 3'h1;
   localparam logic [2:0] NVM_TYPE_FLASH     = 3'h2;
   localparam logic [2:0] NVM_TYPE_ROM_FLASH = 3'h3;
   localparam logic [2:0] NVM_TYPE_SRAM_ROM  = 3'h4;

   typedef struct packed {
      logic       ext_present;  // Bit 31.
      logic [2:0] nvm_type;     // Bits 30:28.
      logic [7:0] family;       // Bits 27:20.
      logic [3:0] sram_size;    // Bits 19:16.
      logic [3:0] nvm2_size;    // Bits 15:12.
      logic [3:0] nvm1_size;    // Bits 11:8.
      logic [2:0] core_type;    // Bits 7:5.
      logic [4:0] version;      // Bits 4:0.
   } chip_id_t;
endpackage

// File: dv/serial_far_end_model.sv
// Far-end model: receiver character source and transmit shifter sink.
`timescale 1ns/100ps
`default_nettype none
module serial_far_end_model (
   input  wire logic       aclk,              // Bench clock.
   input  wire logic       send_req,          // Deliver one character.
   input  wire logic [7:0] send_data,         // Character to deliver.
   input  wire logic [3:0] take_delay,        // Shifter busy cycles.
   input  wire logic       tx_char_pending,   // Character waiting.
   input  wire logic [7:0] character_to_send, // Waiting character.
   output logic            rx_char_valid,     // Receiver char pulse.
   output logic [7:0]      rx_char_data,      // Receiver character.
   output logic            tx_char_taken,     // Shifter took char.
   output logic [7:0]      taken_char         // Last char taken.
);
   logic [3:0] wait_q;
   initial begin
      rx_char_valid = 1'b0;
      rx_char_data = 8'h00;
      tx_char_taken = 1'b0;
      taken_char = 8'h00;
      wait_q = 4'h0;
   end
   // Data outside a pulse toggles so a stale character is never reused.
   always @(posedge aclk) begin
      rx_char_valid <= send_req;
      rx_char_data <= send_req ? send_data : ~rx_char_data;
   end
   always @(posedge aclk) begin
      tx_char_taken <= 1'b0;
      if (tx_char_pending && !tx_char_taken) begin
         wait_q <= wait_q + 4'h1;
         if (wait_q == take_delay) begin
            tx_char_taken <= 1'b1;
            taken_char <= character_to_send;
            wait_q <= 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the debug serial unit register block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [3:0]  flags;
      logic [31:0] addr;
      logic [31:0] data;
      logic [1:0]  resp;
   } row_t;
   localparam dbg_serial_pkg::chip_id_t ID_EXP = '{1'b0,
      dbg_serial_pkg::NVM_TYPE_ROM_FLASH, 8'h5A, 4'hF,
      dbg_serial_pkg::NVM_2048K, dbg_serial_pkg::NVM_32K, 3'h2, 5'h1F};
   localparam row_t ROWS [8] = '{
      '{4'hA, dbg_serial_pkg::ADDR_STATUS, 32'h4000_0802, 2'h0},
      '{4'h5, dbg_serial_pkg::ADDR_STATUS, 32'h8000_1002, 2'h0},
      '{4'h0, dbg_serial_pkg::ADDR_CHIP_ID, ID_EXP, 2'h0},
      '{4'h0, dbg_serial_pkg::ADDR_CHIP_EXT, 32'h0, 2'h0},
      '{4'h0, dbg_serial_pkg::ADDR_BAUD_DIV, 32'h0, 2'h0},
      '{4'h0, dbg_serial_pkg::ADDR_FORCE_TAP, 32'h0, 2'h0},
      '{4'h0, dbg_serial_pkg::ADDR_TX_HOLD, 32'h0, 2'h0},
      '{4'h0, 32'hFFFF_F250, 32'h0, 2'h2}};
   localparam logic [31:0] ST = dbg_serial_pkg::ADDR_STATUS;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, tx_dma_buffer_empty;
   logic rx_dma_buffer_full, debug_channel_write_pending, rx_enabled;
   logic debug_channel_read_pending, rx_char_valid, tx_enabled, send_req;
   logic tx_char_taken, tx_char_pending, baud_tick, power_on_reset_n;
   logic tap_reset_n;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [31:0] rd_data;
   logic [3:0] s_axi_wstrb, take_delay;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] rx_char_data, character_to_send, send_data, taken_char;
   int fail_count = 0;
   int total_checks = 0;
   int ticks;

   debug_serial_unit_regs #(.VERSION(ID_EXP.version),
      .CORE_TYPE(ID_EXP.core_type), .FAMILY(ID_EXP.family),
      .SRAM_SIZE(ID_EXP.sram_size), .NVM1_SIZE(ID_EXP.nvm1_size),
      .NVM2_SIZE(ID_EXP.nvm2_size), .NVM_TYPE(ID_EXP.nvm_type),
      .EXT_PRESENT(1'b0), .EXT_VALUE(32'hDEAD_BEEF)) u_debug_serial_unit_regs (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .tx_dma_buffer_empty,
      .rx_dma_buffer_full, .debug_channel_write_pending,
      .debug_channel_read_pending, .rx_enabled, .rx_char_valid,
      .rx_char_data, .tx_enabled, .tx_char_taken, .tx_char_pending,
      .character_to_send, .baud_tick, .power_on_reset_n, .tap_reset_n);
   serial_far_end_model u_serial_far_end_model (.aclk, .send_req,
      .send_data, .take_delay, .tx_char_pending, .character_to_send,
      .rx_char_valid, .rx_char_data, .tx_char_taken, .taken_char);

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic hang(input int n);
      if (n >= 64) begin
         chk("handshake_timeout", 32'h0, 32'h1);
         print_verdict();
      end
   endtask

   task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
      int n;
      logic aw_hs, w_hs, done;
      logic [1:0] resp;
      n = 0;
      done = 1'b0;
      resp = 2'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw_hs = s_axi_awvalid && s_axi_awready;
         w_hs = s_axi_wvalid && s_axi_wready;
         done = s_axi_bvalid && s_axi_bready;
         resp = s_axi_bresp;
         @(posedge aclk);
         n++;
         if (aw_hs) s_axi_awvalid <= 1'b0;
         if (w_hs) s_axi_wvalid <= 1'b0;
      end while (!done && n < 64);
      s_axi_bready <= 1'b0;
      hang(n);
      chk("bresp", {30'h0, er}, {30'h0, resp});
   endtask

   task automatic axi_rd(input logic [31:0] a, input logic [1:0] er);
      int n;
      logic ar_hs, done;
      logic [1:0] resp;
      n = 0;
      done = 1'b0;
      resp = 2'h0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar_hs = s_axi_arvalid && s_axi_arready;
         done = s_axi_rvalid && s_axi_rready;
         rd_data = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         n++;
         if (ar_hs) s_axi_arvalid <= 1'b0;
      end while (!done && n < 64);
      s_axi_rready <= 1'b0;
      hang(n);
      chk("rresp", {30'h0, er}, {30'h0, resp});
   endtask

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
      {s_axi_rready, send_req, aresetn} = 3'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hF;
      {tx_dma_buffer_empty, rx_dma_buffer_full} = 2'h0;
      {debug_channel_write_pending, debug_channel_read_pending} = 2'h0;
      {rx_enabled, tx_enabled, power_on_reset_n} = 3'h7;
      send_data = 8'h00;
      take_delay = 4'hF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (ROWS[i]) begin
         {tx_dma_buffer_empty, rx_dma_buffer_full} <= ROWS[i].flags[3:2];
         debug_channel_write_pending <= ROWS[i].flags[1];
         debug_channel_read_pending <= ROWS[i].flags[0];
         axi_rd(ROWS[i].addr, ROWS[i].resp);
         chk("table_read", ROWS[i].data, rd_data);
      end
      chk("tap_follow_por", 32'h1, {31'h0, tap_reset_n});
      axi_wr(dbg_serial_pkg::ADDR_CHIP_ID, 32'hFFFF_FFFF, 2'h0);
      axi_wr(32'hFFFF_F250, 32'h1, 2'h2);
      axi_rd(dbg_serial_pkg::ADDR_CHIP_ID, 2'h0);
      chk("id_after_write", ID_EXP, rd_data);
      axi_wr(dbg_serial_pkg::ADDR_FORCE_TAP, 32'hFFFF_FFFF, 2'h0);
      axi_rd(dbg_serial_pkg::ADDR_FORCE_TAP, 2'h0);
      chk("force_read", 32'h1, rd_data);
      repeat (2) @(posedge aclk);
      chk("tap_forced", 32'h0, {31'h0, tap_reset_n});
      axi_wr(dbg_serial_pkg::ADDR_FORCE_TAP, 32'h0, 2'h0);
      power_on_reset_n <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("tap_por_low", 32'h0, {31'h0, tap_reset_n});
      power_on_reset_n <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("tap_released", 32'h1, {31'h0, tap_reset_n});
      for (int d = 0; d < 4; d++) begin
         axi_wr(dbg_serial_pkg::ADDR_BAUD_DIV, 32'hFFFF_0000 | d, 2'h0);
         repeat (40) @(posedge aclk);
         ticks = 0;
         repeat (96) begin
            @(posedge aclk);
            ticks += int'(baud_tick);
         end
         chk("baud_ticks", (d < 2) ? 96 * d : 96 / (16 * d), ticks);
         axi_rd(dbg_serial_pkg::ADDR_BAUD_DIV, 2'h0);
         chk("baud_read", d, rd_data);
      end
      for (int k = 0; k < 3; k++) begin
         @(posedge aclk);
         send_data <= 8'h11 * (k + 1);
         send_req <= 1'b1;
         @(posedge aclk);
         send_req <= 1'b0;
      end
      repeat (3) @(posedge aclk);
      axi_rd(ST, 2'h0);
      chk("rx_ready_set", 32'h1, rd_data & 32'h1);
      axi_rd(dbg_serial_pkg::ADDR_RX_HOLD, 2'h0);
      chk("rx_char", 32'h33, rd_data);
      axi_rd(ST, 2'h0);
      chk("rx_ready_clr", 32'h0, rd_data & 32'h1);
      send_req <= 1'b1;
      @(posedge aclk);
      send_req <= 1'b0;
      rx_enabled <= 1'b0;
      repeat (3) @(posedge aclk);
      axi_rd(ST, 2'h0);
      chk("rx_ready_off", 32'h0, rd_data & 32'h1);
      axi_wr(dbg_serial_pkg::ADDR_TX_HOLD, 32'h0000_013C, 2'h0);
      axi_rd(ST, 2'h0);
      chk("tx_free_busy", 32'h0, rd_data & 32'h2);
      chk("char_out", 32'h3C, {24'h0, character_to_send});
      ticks = 0;
      while (tx_char_pending !== 1'b0 && ticks < 64) begin
         @(posedge aclk);
         ticks++;
      end
      hang(ticks);
      chk("char_taken", 32'h3C, {24'h0, taken_char});
      axi_rd(ST, 2'h0);
      chk("tx_free_idle", 32'h2, rd_data & 32'h2);
      tx_enabled <= 1'b0;
      axi_rd(ST, 2'h0);
      chk("tx_free_off", 32'h0, rd_data & 32'h2);
      print_verdict();
   end
endmodule
`default_nettype wire
